// [design/park_consts.svh]
// Named constants for the reset and mirror-park controller.
// Assumes a 25 MHz system clock; included by the design modules.
`ifndef PARK_CONSTS_SVH
`define PARK_CONSTS_SVH

// Clock rate in MHz (period 40 ns)
`define CLK_MHZ 25
// Self-configuration time after reset release, in us
`define CONFIG_TIME_US 1000
`define CONFIG_CYCLES (`CONFIG_TIME_US * `CLK_MHZ)
// Fast park sequence length, in us; finishes well inside 40 us
`define FAST_PARK_TIME_US 20
`define FAST_PARK_CYCLES (`FAST_PARK_TIME_US * `CLK_MHZ)
// Normal park sequence length, in us
`define NORMAL_PARK_TIME_US 10000
`define NORMAL_PARK_CYCLES (`NORMAL_PARK_TIME_US * `CLK_MHZ)
// Longest normal park allowed, in ms
`define NORMAL_PARK_MAX_MS 20
`define NORMAL_PARK_MAX_CYCLES (`NORMAL_PARK_MAX_MS * 1000 * `CLK_MHZ)
// Quiet time before configuration bus is allowed, in ms
`define BUS_GUARD_TIME_MS 500
`define BUS_GUARD_CYCLES (`BUS_GUARD_TIME_MS * 1000 * `CLK_MHZ)
// Counter width, covers the longest count
`define CNT_W 24
// Synchroniser layout: bit 0 reset, bit 1 fast park, bit 2 normal park
`define SYNC_W 3
`define SYNC_POR 0
`define SYNC_FAST 1
`define SYNC_NORMAL 2
`define SYNC_RESET_VAL 3'h4
// Widths of the tri-stated pin groups
`define FLASH_W 4
`define PWR_IC_W 4
`define PULSE_W 2
`define GPIN_W 15

`endif

// [design/park_pkg.sv]
// Types for the reset and mirror-park controller.
// Used by the top module; constants live in park_consts.svh.
package park_pkg;

   // Gray-coded along hold, config, run, normal park, fast park, parked
   typedef enum logic [2:0] {
      ST_HOLD = 3'h0,
      ST_CONFIG = 3'h1,
      ST_RUN = 3'h3,
      ST_NORMAL_PARK = 3'h2,
      ST_FAST_PARK = 3'h6,
      ST_PARKED = 3'h7
   } park_state_type;

endpackage : park_pkg

// [design/sync_if.sv]
// Carries raw pin levels to the synchroniser and clean levels back.
// Assumes both ends sit on the one system clock.
`timescale 1ns/1ps
`include "park_consts.svh"

interface sync_if;
   logic [`SYNC_W-1:0] raw;
   logic [`SYNC_W-1:0] clean;

   modport ctrl (output raw, input clean);
   modport sync (input raw, output clean);
endinterface : sync_if

// [design/input_sync.sv]
// Three-stage pin synchroniser with agreement filter.
// Assumes raw levels are asynchronous to clk; rst is async, high.
`timescale 1ns/1ps
`include "park_consts.svh"

module input_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pin levels in, clean levels out
   sync_if.sync port
);

   // Per-bit reset levels of the stages, picked out one bit at a time
   localparam logic [`SYNC_W-1:0] SYNC_RESET_LVL = `SYNC_RESET_VAL;

   genvar i;
   generate
      for (i = 0; i < `SYNC_W; i++) begin : g_bit
         logic s1_r, s2_r, s3_r, clean_r;
         logic clean_nxt;

         // A change counts once stages two and three agree
         always_comb begin
            clean_nxt = clean_r;
            if (s2_r == s3_r) begin
               clean_nxt = s3_r;
            end
         end

         // Stage one feeds stage two only
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               s1_r <= SYNC_RESET_LVL[i];
               s2_r <= SYNC_RESET_LVL[i];
               s3_r <= SYNC_RESET_LVL[i];
               clean_r <= SYNC_RESET_LVL[i];
            end else begin
               s1_r <= port.raw[i];
               s2_r <= s1_r;
               s3_r <= s2_r;
               clean_r <= clean_nxt;
            end
         end

         assign port.clean[i] = clean_r;
      end
   endgenerate

endmodule : input_sync

// [design/reset_and_mirror_park_control.sv]
// Reset sequencing and mirror-park control of the display controller.
// Assumes pins arrive unsynchronised; power IC and host keep their side.
`timescale 1ns/1ps
`include "park_consts.svh"

module reset_and_mirror_park_control
   import park_pkg::*;
#(
   parameter int CONFIG_CYCLES = `CONFIG_CYCLES,
   parameter int NORMAL_PARK_CYCLES = `NORMAL_PARK_CYCLES,
   parameter int BUS_GUARD_CYCLES = `BUS_GUARD_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pins from power IC and host
   input wire logic por_in_n,
   input wire logic fast_mirror_halt_n,
   input wire logic normal_mirror_halt_req,
   // Output enables of tri-stated pin groups
   output logic [`FLASH_W-1:0] flash_oe,
   output logic [`PWR_IC_W-1:0] pwr_ic_oe,
   output logic [`PULSE_W-1:0] sync_pulse_oe,
   output logic [`GPIN_W-1:0] general_pins_oe,
   // Outputs forced low in hold; raised in run, mirror enable also in normal and fast park but low once parked
   output logic light_source_select,
   output logic mirror_array_enable_n,
   // Host interrupt pin
   output logic host_irq,
   output logic host_irq_oe,
   // Status
   output logic mirrors_parked,
   output logic config_bus_ok
);

   sync_if sif ();
   logic por_f, fast_f, normal_f, por_d_r;
   park_state_type state_r, state_nxt;
   logic [`CNT_W-1:0] cnt_r, cnt_nxt, guard_r, guard_nxt;
   logic io_on, run_nxt;
   logic [`FLASH_W-1:0] flash_oe_nxt;
   logic [`PWR_IC_W-1:0] pwr_ic_oe_nxt;
   logic [`PULSE_W-1:0] sync_pulse_oe_nxt;
   logic [`GPIN_W-1:0] general_pins_oe_nxt;
   logic lss_nxt, mae_n_nxt, irq_nxt, irq_oe_nxt, parked_nxt, bus_ok_nxt;

   // Pins pass the three-stage synchroniser
   assign sif.raw[`SYNC_POR] = por_in_n;
   assign sif.raw[`SYNC_FAST] = fast_mirror_halt_n;
   assign sif.raw[`SYNC_NORMAL] = normal_mirror_halt_req;
   assign por_f = sif.clean[`SYNC_POR];
   assign fast_f = sif.clean[`SYNC_FAST];
   assign normal_f = sif.clean[`SYNC_NORMAL];

   input_sync u_sync (
      .clk (clk),
      .rst (rst),
      .port (sif.sync)
   );

   // Sequencer next state and phase counter
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_HOLD: begin
            if (por_f && !por_d_r) begin
               state_nxt = ST_CONFIG;
            end
         end
         ST_CONFIG: begin
            if (!fast_f) begin
               state_nxt = ST_FAST_PARK;
            end else if (cnt_r == `CNT_W'(CONFIG_CYCLES - 1)) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!fast_f) begin
               state_nxt = ST_FAST_PARK;
            end else if (!normal_f) begin
               state_nxt = ST_NORMAL_PARK;
            end
         end
         ST_NORMAL_PARK: begin
            if (!fast_f) begin
               state_nxt = ST_FAST_PARK;
            end else if (cnt_r == `CNT_W'(NORMAL_PARK_CYCLES - 1)) begin
               state_nxt = ST_PARKED;
            end
         end
         ST_FAST_PARK: begin
            if (cnt_r == `CNT_W'(`FAST_PARK_CYCLES - 1)) begin
               state_nxt = ST_PARKED;
            end
         end
         ST_PARKED: begin
            if (fast_f && normal_f) begin
               state_nxt = ST_RUN;
            end
         end
         default: state_nxt = ST_HOLD;
      endcase
      if (!por_f) begin
         state_nxt = ST_HOLD;
      end
      if (state_nxt != state_r) begin
         cnt_nxt = '0;
      end else begin
         cnt_nxt = cnt_r + `CNT_W'(1);
      end
   end

   // Bus guard counts from both reset and fast park high
   always_comb begin
      guard_nxt = guard_r;
      bus_ok_nxt = 1'b0;
      if (!por_f || !fast_f) begin
         guard_nxt = '0;
      end else if (guard_r == `CNT_W'(BUS_GUARD_CYCLES)) begin
         bus_ok_nxt = 1'b1;
      end else begin
         guard_nxt = guard_r + `CNT_W'(1);
      end
   end

   // Output levels follow the next state so they align with state_r
   always_comb begin
      io_on = (state_nxt != ST_HOLD);
      run_nxt = (state_nxt == ST_RUN);
      flash_oe_nxt = {`FLASH_W{io_on}};
      pwr_ic_oe_nxt = {`PWR_IC_W{io_on}};
      sync_pulse_oe_nxt = {`PULSE_W{io_on}};
      general_pins_oe_nxt = {`GPIN_W{io_on}};
      lss_nxt = run_nxt;
      mae_n_nxt = run_nxt || (state_nxt == ST_NORMAL_PARK)
         || (state_nxt == ST_FAST_PARK);
      irq_oe_nxt = io_on;
      irq_nxt = (state_nxt == ST_CONFIG);
      parked_nxt = (state_nxt == ST_PARKED);
   end

   // State, counters and output registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_HOLD;
         cnt_r <= '0;
         guard_r <= '0;
         por_d_r <= 1'b0;
         flash_oe <= '0;
         pwr_ic_oe <= '0;
         sync_pulse_oe <= '0;
         general_pins_oe <= '0;
         light_source_select <= 1'b0;
         mirror_array_enable_n <= 1'b0;
         host_irq <= 1'b0;
         host_irq_oe <= 1'b0;
         mirrors_parked <= 1'b0;
         config_bus_ok <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         guard_r <= guard_nxt;
         por_d_r <= por_f;
         flash_oe <= flash_oe_nxt;
         pwr_ic_oe <= pwr_ic_oe_nxt;
         sync_pulse_oe <= sync_pulse_oe_nxt;
         general_pins_oe <= general_pins_oe_nxt;
         light_source_select <= lss_nxt;
         mirror_array_enable_n <= mae_n_nxt;
         host_irq <= irq_nxt;
         host_irq_oe <= irq_oe_nxt;
         mirrors_parked <= parked_nxt;
         config_bus_ok <= bus_ok_nxt;
      end
   end

   // Checks on the sequencer and its outputs
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_reset_drop;
      $fell(por_f);
   endsequence
   sequence s_all_floating;
      (flash_oe == '0) && (pwr_ic_oe == '0) && (sync_pulse_oe == '0)
         && (general_pins_oe == '0) && !host_irq_oe;
   endsequence

   property p_hold_float;
      s_reset_drop |=> ((state_r == ST_HOLD) and s_all_floating);
   endproperty
   a_hold_float: assert property (p_hold_float)
      else $error("pins not floated after reset drop");

   property p_hold_low;
      (state_r == ST_HOLD) |-> !light_source_select && !mirror_array_enable_n;
   endproperty
   a_hold_low: assert property (p_hold_low)
      else $error("lamp select or mirror enable high in reset");

   property p_hold_stays;
      !por_f ##1 !por_f |-> (state_r == ST_HOLD) && !mirrors_parked;
   endproperty
   a_hold_stays: assert property (p_hold_stays)
      else $error("left hold while reset asserted");

   property p_config_start;
      (state_r == ST_HOLD) && $rose(por_f) |=>
         (state_r == ST_CONFIG) && host_irq && host_irq_oe;
   endproperty
   a_config_start: assert property (p_config_start)
      else $error("configuration did not start on reset rise");

   property p_fast_exit;
      (state_r == ST_RUN) && !fast_f && por_f |=>
         (state_r == ST_FAST_PARK) && !light_source_select;
   endproperty
   a_fast_exit: assert property (p_fast_exit)
      else $error("run continued with fast park low");

   property p_normal_enter;
      (state_r == ST_RUN) && fast_f && !normal_f && por_f |=>
         (state_r == ST_NORMAL_PARK) && mirror_array_enable_n
         && !light_source_select;
   endproperty
   a_normal_enter: assert property (p_normal_enter)
      else $error("normal park not entered on request");

   property p_normal_bound;
      (state_r == ST_NORMAL_PARK) |->
         cnt_r < `CNT_W'(`NORMAL_PARK_MAX_CYCLES);
   endproperty
   a_normal_bound: assert property (p_normal_bound)
      else $error("normal park exceeded its time limit");

   property p_bus_gate;
      !por_f || !fast_f |=> !config_bus_ok [*2];
   endproperty
   a_bus_gate: assert property (p_bus_gate)
      else $error("bus allowed too early");

   property p_irq_done;
      (state_r == ST_CONFIG) ##1 (state_r == ST_RUN) |->
         !host_irq && host_irq_oe;
   endproperty
   a_irq_done: assert property (p_irq_done)
      else $error("interrupt did not show end of initialisation");

endmodule : reset_and_mirror_park_control

// [testbench/pwr_host_model.sv]
// Behavioural power IC and host processor on the controller's pins.
// Assumes the bench calls its tasks; pins change on falling clk edges.
`timescale 1ns/1ps

module pwr_host_model #(
   parameter int FAST_HOLD_CYCLES = 1000
) (
   // Clock
   input wire logic clk,
   // Pins towards the controller
   output logic por_in_n,
   output logic fast_mirror_halt_n,
   output logic normal_mirror_halt_req
);

   // Supplies off: reset and fast park low, no park request
   initial begin
      por_in_n = 1'b0;
      fast_mirror_halt_n = 1'b0;
      normal_mirror_halt_req = 1'b1;
   end

   // Release reset only once supplies are up, fast park raised first
   task power_up;
      @(negedge clk);
      fast_mirror_halt_n = 1'b1;
      repeat (4) @(negedge clk);
      por_in_n = 1'b1;
   endtask : power_up

   // Ordinary shutdown path; reset and supplies stay up meanwhile
   task host_park(input logic lvl);
      @(negedge clk);
      normal_mirror_halt_req = lvl;
   endtask : host_park

   // Imminent power loss: fast park, hold 40 us, then drop reset
   task power_down;
      @(negedge clk);
      fast_mirror_halt_n = 1'b0;
      repeat (FAST_HOLD_CYCLES) @(negedge clk);
      por_in_n = 1'b0;
   endtask : power_down

endmodule : pwr_host_model

// [testbench/tb.sv]
// Self-checking bench of the reset and mirror-park controller.
// Assumes shortened count parameters; pins come from pwr_host_model.
`timescale 1ns/1ps

`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
   miscompares++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
`define WAIT_FOR(c, n) \
   for (int k_ = 0; k_ < (n) && !(c); k_++) @(negedge clk)

module tb;
   localparam int CFG = 20;
   localparam int NPK = 1200;
   localparam int GRD = 30;
   localparam int FPK = 500;
   localparam int LIMIT = 20000;

   logic clk, rst;
   logic por_in_n, fast_mirror_halt_n, normal_mirror_halt_req;
   logic [3:0] flash_oe, pwr_ic_oe;
   logic [1:0] sync_pulse_oe;
   logic [14:0] general_pins_oe;
   logic light_source_select, mirror_array_enable_n;
   logic host_irq, host_irq_oe, mirrors_parked, config_bus_ok;
   logic [24:0] oes;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;

   assign oes = {flash_oe, pwr_ic_oe, sync_pulse_oe, general_pins_oe};

   // Device under test with shortened counts
   reset_and_mirror_park_control #(
      .CONFIG_CYCLES(CFG),
      .NORMAL_PARK_CYCLES(NPK),
      .BUS_GUARD_CYCLES(GRD)
   ) u_dut (
      .clk(clk), .rst(rst), .por_in_n(por_in_n),
      .fast_mirror_halt_n(fast_mirror_halt_n),
      .normal_mirror_halt_req(normal_mirror_halt_req),
      .flash_oe(flash_oe), .pwr_ic_oe(pwr_ic_oe),
      .sync_pulse_oe(sync_pulse_oe), .general_pins_oe(general_pins_oe),
      .light_source_select(light_source_select),
      .mirror_array_enable_n(mirror_array_enable_n),
      .host_irq(host_irq), .host_irq_oe(host_irq_oe),
      .mirrors_parked(mirrors_parked), .config_bus_ok(config_bus_ok)
   );

   // Far side: power IC and host
   pwr_host_model u_host (
      .clk(clk), .por_in_n(por_in_n),
      .fast_mirror_halt_n(fast_mirror_halt_n),
      .normal_mirror_halt_req(normal_mirror_halt_req)
   );

   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         end_sim();
      end
   end

   task end_sim;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim

   // Everything inactive, tri-stated or low while reset pin is low
   task check_hold;
      `CHK(oes, 25'h0)
      `CHK({light_source_select, mirror_array_enable_n}, 2'h0)
      `CHK({host_irq_oe, mirrors_parked, config_bus_ok}, 3'h0)
   endtask : check_hold

   // Reset release starts configuration, then run; bus guard timing
   task t_power_up;
      int t0;
      u_host.power_up();
      t0 = cycles;
      `WAIT_FOR(host_irq === 1'b1, 12);
      `CHK(host_irq, 1'b1)
      `CHK({oes, host_irq_oe}, 26'h3FFFFFF)
      `CHK(config_bus_ok, 1'b0)
      `WAIT_FOR(host_irq === 1'b0, CFG + 4);
      `CHK({light_source_select, mirror_array_enable_n}, 2'h3)
      `CHK(host_irq, 1'b0)
      while (cycles < t0 + GRD) @(negedge clk);
      `CHK(config_bus_ok, 1'b0)
      `WAIT_FOR(config_bus_ok === 1'b1, 10);
      `CHK(config_bus_ok, 1'b1)
   endtask : t_power_up

   // Slow park: lamp off, mirrors kept on past 40 us, done in bound
   task t_normal_park;
      u_host.host_park(1'b0);
      `WAIT_FOR(light_source_select === 1'b0, 10);
      `CHK(light_source_select, 1'b0)
      repeat (1000) @(negedge clk);
      `CHK({mirrors_parked, mirror_array_enable_n}, 2'h1)
      `WAIT_FOR(mirrors_parked === 1'b1, NPK);
      `CHK({mirrors_parked, mirror_array_enable_n}, 2'h2)
      `CHK({host_irq_oe, config_bus_ok}, 2'h3)
      u_host.host_park(1'b1);
      `WAIT_FOR(light_source_select === 1'b1, 10);
      `CHK({light_source_select, mirrors_parked}, 2'h2)
   endtask : t_normal_park

   // Fast park on power loss, then reset pin drops
   task t_power_down;
      fork
         u_host.power_down();
         begin
            `WAIT_FOR(mirrors_parked === 1'b1, FPK + 12);
            `CHK({mirrors_parked, light_source_select}, 2'h2)
            `CHK(config_bus_ok, 1'b0)
         end
      join
      `WAIT_FOR(host_irq_oe === 1'b0, 10);
      check_hold();
   endtask : t_power_down

   // Main sequence
   initial begin
      rst = 1'b1;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      repeat (10) @(negedge clk);
      check_hold();
      t_power_up();
      t_normal_park();
      t_power_down();
      t_power_up();
      end_sim();
   end

endmodule : tb
